// file: core/pwc_pkg.sv
// Constants shared by the periodic wakeup counter design
package pwc_pkg;

	// Bus geometry and prescaler ratio width
	localparam int          PWC_ADDR_W      = 12;
	localparam int          PWC_DATA_W      = 32;
	localparam int          PWC_RATIO_W     = 18;

	// Register byte offsets
	localparam logic [11:0] PWC_OFS_CTRL    = 12'h000;
	localparam logic [11:0] PWC_OFS_COUNT   = 12'h004;
	localparam logic [11:0] PWC_OFS_WRAP    = 12'h008;

	// Control register field positions
	localparam int          PWC_FLAG_BIT    = 7;
	localparam int          PWC_SRC_HI      = 6;
	localparam int          PWC_SRC_LO      = 5;
	localparam int          PWC_IE_BIT      = 4;
	localparam int          PWC_DIV_HI      = 3;
	localparam int          PWC_DIV_LO      = 0;

	// Source select codes
	localparam logic [1:0]  PWC_SRC_LPO     = 2'h0;
	localparam logic [1:0]  PWC_SRC_EXT     = 2'h1;

	// Reset values and the divider-off code
	localparam logic [1:0]  PWC_SRC_RST     = 2'h0;
	localparam logic [3:0]  PWC_DIV_RST     = 4'h0;
	localparam logic [7:0]  PWC_WRAP_RST    = 8'h00;
	localparam logic [7:0]  PWC_COUNT_RST   = 8'h00;
	localparam logic [3:0]  PWC_DIV_OFF     = 4'h0;

endpackage : pwc_pkg

// file: core/pwc_edge_sync.sv
// Two-stage synchroniser with rising-edge pulse for the source clocks
`timescale 1ns/100ps
`default_nettype none

module pwc_edge_sync #(
	parameter int W = 3
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Asynchronous levels in, one-cycle edge pulses out
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] rise
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] next_rise;

	// Edge found on the second stage only; first stage feeds nothing else
	always_comb begin
		next_rise = stage2 & ~stage3;
	end

	// Sync chain and registered pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			rise   <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			rise   <= next_rise;
		end
	end

endmodule : pwc_edge_sync

`default_nettype wire

// file: core/pwc_top.sv
// Periodic wakeup counter: source select, prescaler, wrap counter, APB
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module pwc_top
	import pwc_pkg::*;
(
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [PWC_ADDR_W-1:0] paddr,
	input  wire logic [PWC_DATA_W-1:0] pwdata,
	output var  logic [PWC_DATA_W-1:0] prdata,
	output var  logic                  pready,
	output var  logic                  pslverr,
	// Source clocks, asynchronous to pclk
	// Each must stay below half the pclk rate; only its edges are used
	input  wire logic                  low_power_osc_clock,
	input  wire logic                  external_ref_clock,
	input  wire logic                  internal_ref_clock,
	// Interrupt request
	output var  logic                  match_irq
);

	// Divide ratio for a divider code and source bit 0
	// Binary ratios on codes 1-7, decimal on 8-15; source bit 0 picks
	// the slow or fast row, so one table serves all three sources
	function automatic logic [PWC_RATIO_W-1:0] pwc_ratio(
		input logic       src0,
		input logic [3:0] div
	);
		logic [PWC_RATIO_W-1:0] r;
		r = 18'h00001;
		unique case ({src0, div})
			5'h01: r = 18'h00008;
			5'h02: r = 18'h00020;
			5'h03: r = 18'h00040;
			5'h04: r = 18'h00080;
			5'h05: r = 18'h00100;
			5'h06: r = 18'h00200;
			5'h07: r = 18'h00400;
			5'h08: r = 18'h00001;
			5'h09: r = 18'h00002;
			5'h0A: r = 18'h00004;
			5'h0B: r = 18'h0000A;
			5'h0C: r = 18'h00010;
			5'h0D: r = 18'h00064;
			5'h0E: r = 18'h001F4;
			5'h0F: r = 18'h003E8;
			5'h11: r = 18'h00400;
			5'h12: r = 18'h00800;
			5'h13: r = 18'h01000;
			5'h14: r = 18'h02000;
			5'h15: r = 18'h04000;
			5'h16: r = 18'h08000;
			5'h17: r = 18'h10000;
			5'h18: r = 18'h003E8;
			5'h19: r = 18'h007D0;
			5'h1A: r = 18'h01388;
			5'h1B: r = 18'h02710;
			5'h1C: r = 18'h04E20;
			5'h1D: r = 18'h0C350;
			5'h1E: r = 18'h186A0;
			5'h1F: r = 18'h30D40;
			default: r = 18'h00001;
		endcase
		return r;
	endfunction : pwc_ratio

	// Register state
	logic [1:0]             tick_source_select;
	logic [3:0]             rate_divider_select;
	logic                   match_irq_enable;
	logic                   match_flag;
	logic [7:0]             wrap_compare_value;
	logic [7:0]             tick_count_value;
	// Prescaler position counts selected source edges, not pclk cycles
	logic [PWC_RATIO_W-1:0] pre_count;

	// Next values
	logic [1:0]             next_tick_source_select;
	logic [3:0]             next_rate_divider_select;
	logic                   next_match_irq_enable;
	logic                   next_match_flag;
	logic [7:0]             next_wrap_compare_value;
	logic [7:0]             next_tick_count_value;
	logic [PWC_RATIO_W-1:0] next_pre_count;
	logic [PWC_DATA_W-1:0]  next_prdata;
	logic                   next_pready;
	logic                   next_pslverr;
	logic                   next_match_irq;

	// Helpers
	logic [2:0]             src_rise;
	logic                   src_edge;
	logic                   tick;
	logic                   presc_on;
	logic                   wr_access;
	logic                   setup;
	logic                   hit_ctrl;
	logic                   hit_count;
	logic                   hit_wrap;
	logic                   clear_counters;
	logic [PWC_RATIO_W-1:0] ratio;

	// Sources are only sampled, never used as clocks: one domain, and a
	// source switch cannot produce runt pulses
	// sync sources
	pwc_edge_sync #(
		.W (3)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({internal_ref_clock, external_ref_clock,
			low_power_osc_clock}),
		.rise     (src_rise)
	);

	// Bus decode; access completes in the cycle after setup
	always_comb begin
		setup     = psel && !penable;
		hit_ctrl  = (paddr == PWC_OFS_CTRL);
		hit_count = (paddr == PWC_OFS_COUNT);
		hit_wrap  = (paddr == PWC_OFS_WRAP);
		// Writes land only at the access edge, with pready high
		wr_access = psel && penable && pready && pwrite;
	end

	// Source pick and tick generation
	always_comb begin
		unique case (tick_source_select)
			PWC_SRC_LPO: src_edge = src_rise[0];
			PWC_SRC_EXT: src_edge = src_rise[1];
			default:     src_edge = src_rise[2];
		endcase
		ratio = pwc_ratio(tick_source_select[0], rate_divider_select);
		presc_on = (rate_divider_select != PWC_DIV_OFF);
		tick     = src_edge && presc_on
			&& (pre_count == ratio - 18'h00001);
	end

	// Control register and clear decisions
	always_comb begin
		next_tick_source_select  = tick_source_select;
		next_rate_divider_select = rate_divider_select;
		next_match_irq_enable    = match_irq_enable;
		next_wrap_compare_value  = wrap_compare_value;
		clear_counters           = 1'b0;
		// Rewriting unchanged fields keeps the counters running, so a
		// flag clear does not lose the count phase
		if (wr_access && hit_ctrl) begin
			next_tick_source_select  = pwdata[PWC_SRC_HI:PWC_SRC_LO];
			next_rate_divider_select = pwdata[PWC_DIV_HI:PWC_DIV_LO];
			next_match_irq_enable    = pwdata[PWC_IE_BIT];
			if (pwdata[PWC_SRC_HI:PWC_SRC_LO] != tick_source_select) begin
				clear_counters = 1'b1;
			end
			if (pwdata[PWC_DIV_HI:PWC_DIV_LO] != rate_divider_select) begin
				clear_counters = 1'b1;
			end
		end
		if (wr_access && hit_wrap) begin
			next_wrap_compare_value = pwdata[7:0];
			clear_counters          = 1'b1;
		end
	end

	// Prescaler, counter and flag
	always_comb begin
		next_pre_count        = pre_count;
		next_tick_count_value = tick_count_value;
		next_match_flag       = match_flag;
		if (wr_access && hit_ctrl && pwdata[PWC_FLAG_BIT]) begin
			next_match_flag = 1'b0;
		end
		// A clearing write outranks a tick in the same cycle, so a new
		// setting always starts from an empty prescaler
		if (clear_counters) begin
			next_pre_count        = '0;
			next_tick_count_value = PWC_COUNT_RST;
		end else if (src_edge && presc_on) begin
			// Prescaler restarts on each tick
			// decimal and binary share one counter
			next_pre_count = tick ? '0 : pre_count + 18'h00001;
			if (tick) begin
				if (tick_count_value == wrap_compare_value) begin
					next_tick_count_value = PWC_COUNT_RST;
					// set on wrap; set beats clear
					next_match_flag       = 1'b1;
				end else begin
					next_tick_count_value = tick_count_value + 8'h01;
				end
			end
		end
	end

	// Bus answer and interrupt; read data is taken at setup, so a count
	// read shows the value of the setup cycle, the cycle before the access cycle
	always_comb begin
		next_pready  = setup;
		// Unmapped addresses answer with an error and change nothing
		next_pslverr = setup && !(hit_ctrl || hit_count || hit_wrap);
		next_prdata  = '0;
		if (setup && hit_ctrl) begin
			next_prdata[PWC_FLAG_BIT]          = match_flag;
			next_prdata[PWC_SRC_HI:PWC_SRC_LO] = tick_source_select;
			next_prdata[PWC_IE_BIT]            = match_irq_enable;
			next_prdata[PWC_DIV_HI:PWC_DIV_LO] = rate_divider_select;
		end else if (setup && hit_count) begin
			next_prdata[7:0] = tick_count_value;
		end else if (setup && hit_wrap) begin
			next_prdata[7:0] = wrap_compare_value;
		end
		// Built from next values so the request moves with the flag
		// flag and enable
		next_match_irq = next_match_flag && next_match_irq_enable;
	end

	// Control fields; reset leaves the prescaler off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_source_select  <= PWC_SRC_RST;
			rate_divider_select <= PWC_DIV_RST;
			match_irq_enable    <= 1'b0;
			wrap_compare_value  <= PWC_WRAP_RST;
		end else begin
			tick_source_select  <= next_tick_source_select;
			rate_divider_select <= next_rate_divider_select;
			match_irq_enable    <= next_match_irq_enable;
			wrap_compare_value  <= next_wrap_compare_value;
		end
	end

	// Prescaler, counter and flag registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_flag       <= 1'b0;
			tick_count_value <= PWC_COUNT_RST;
			pre_count        <= '0;
		end else begin
			match_flag       <= next_match_flag;
			tick_count_value <= next_tick_count_value;
			pre_count        <= next_pre_count;
		end
	end

	// Bus answer and request, each straight from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata    <= '0;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			match_irq <= 1'b0;
		end else begin
			prdata    <= next_prdata;
			pready    <= next_pready;
			pslverr   <= next_pslverr;
			match_irq <= next_match_irq;
		end
	end

endmodule : pwc_top

`default_nettype wire

// file: bench/pwc_top_checker.sv
// Bus and request checks for the periodic wakeup counter
`timescale 1ns/100ps
`default_nettype none
module pwc_top_checker
	import pwc_pkg::*;
(
	// Clock and reset
	input wire logic                  pclk,
	input wire logic                  presetn,
	// APB slave side
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [PWC_ADDR_W-1:0] paddr,
	input wire logic [PWC_DATA_W-1:0] pwdata,
	input wire logic [PWC_DATA_W-1:0] prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	// Request
	input wire logic                  match_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Transfer phases
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence

	// Shadow of written fields, so readback has an independent reference
	logic [6:0] ctl_q;
	logic [7:0] wrp_q;
	wire logic  wr_hit = psel && penable && pready && pwrite;
	wire logic  hit = paddr inside {PWC_OFS_CTRL, PWC_OFS_COUNT, PWC_OFS_WRAP};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= 7'h00;
			wrp_q <= 8'h00;
		end else if (wr_hit && paddr == PWC_OFS_CTRL) begin
			ctl_q <= pwdata[6:0];
		end else if (wr_hit && paddr == PWC_OFS_WRAP) begin
			wrp_q <= pwdata[7:0];
		end
	end

	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_unmapped: assert property (s_setup ##0 !hit |=> pslverr)
		else $error("no error for unmapped address");
	a_err_zero_data: assert property (pslverr |-> pready && prdata == '0)
		else $error("error response carries data");
	a_upper_zero: assert property (pready |-> prdata[31:8] == '0)
		else $error("upper read bits not zero");
	a_irq_enable_off: assert property (s_done ##0 pwrite
		&& paddr == PWC_OFS_CTRL && !pwdata[PWC_IE_BIT] |=> !match_irq)
		else $error("request survives disable");
	a_wrap_readback: assert property (s_done ##0 !pwrite
		&& paddr == PWC_OFS_WRAP |-> prdata[7:0] == wrp_q)
		else $error("wrap value readback wrong");
	a_ctrl_readback: assert property (s_done ##0 !pwrite
		&& paddr == PWC_OFS_CTRL |-> prdata[6:0] == ctl_q)
		else $error("control readback wrong");
endmodule : pwc_top_checker
`default_nettype wire

// file: bench/testbench.sv
// Directed register-level testbench for the periodic wakeup counter
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pwc_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr;
	logic        match_irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0]  src;
	int          compares, miscompares, dv[5], tk[5], ex[5], s, m, n;

	pwc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .low_power_osc_clock(src[0]),
		.external_ref_clock(src[1]), .internal_ref_clock(src[2]),
		.match_irq(match_irq));

	// 10 MHz bus clock
	always #50 pclk = ~pclk;

	task automatic stop_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; waits for pready, no fixed latency assumed
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so a following call never re-drives psel now
		@(posedge pclk);
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask : rd

	// Request is sampled one edge later so its update has landed
	task automatic irq(input logic x);
		@(posedge pclk);
		chk({31'h0, match_irq}, {31'h0, x});
	endtask : irq

	// Rising edges on masked sources, slower than pclk/2
	task automatic tick(input logic [2:0] k, input int c);
		repeat (c) begin
			src <= k;
			repeat (4) @(posedge pclk);
			src <= 3'h0;
			repeat (4) @(posedge pclk);
		end
	endtask : tick

	// Hang guard, about three and a half times the expected run
	initial begin
		repeat (60000) @(posedge pclk);
		miscompares++;
		stop_test();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, src} = '0;
		dv = '{8, 9, 10, 1, 11};
		tk = '{5, 4, 8, 16, 20};
		ex = '{5, 2, 2, 2, 2};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(PWC_OFS_CTRL, 32'h0);
		rd(PWC_OFS_WRAP, 32'h0);
		apb(1'b0, 12'h00C, 32'h0);
		chk({q[30:0], e}, 32'h1);
		tick(3'h7, 3);
		rd(PWC_OFS_COUNT, 32'h0);
		apb(1'b1, PWC_OFS_WRAP, 32'hFF);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, PWC_OFS_CTRL, dv[i]);
			tick(3'h1, tk[i]);
			rd(PWC_OFS_COUNT, ex[i]);
		end
		apb(1'b1, PWC_OFS_CTRL, 32'h0B);
		rd(PWC_OFS_COUNT, 32'h2);
		// Sources in an order where every step changes the select field
		foreach (dv[i]) if (i < 4) begin
			s = (i + 2) % 4;
			m = (s == 0) ? 1 : (s == 1) ? 2 : 4;
			n = s[0] ? 1000 : 3;
			apb(1'b1, PWC_OFS_CTRL, (s << 5) | 8);
			rd(PWC_OFS_COUNT, 32'h0);
			tick(3'h7 & ~m[2:0], 3);
			tick(m[2:0], n);
			rd(PWC_OFS_COUNT, s[0] ? 1 : 3);
		end
		apb(1'b1, PWC_OFS_CTRL, 32'h18);
		apb(1'b1, PWC_OFS_WRAP, 32'h03);
		tick(3'h1, 3);
		rd(PWC_OFS_COUNT, 32'h3);
		rd(PWC_OFS_CTRL, 32'h18);
		tick(3'h1, 1);
		rd(PWC_OFS_COUNT, 32'h0);
		rd(PWC_OFS_CTRL, 32'h98);
		irq(1'b1);
		apb(1'b1, PWC_OFS_CTRL, 32'h18);
		rd(PWC_OFS_CTRL, 32'h98);
		apb(1'b1, PWC_OFS_CTRL, 32'h08);
		irq(1'b0);
		apb(1'b1, PWC_OFS_CTRL, 32'h98);
		rd(PWC_OFS_CTRL, 32'h18);
		irq(1'b0);
		tick(3'h1, 2);
		apb(1'b1, PWC_OFS_COUNT, 32'hFF);
		rd(PWC_OFS_COUNT, 32'h2);
		apb(1'b1, PWC_OFS_WRAP, 32'h03);
		rd(PWC_OFS_COUNT, 32'h0);
		apb(1'b1, PWC_OFS_WRAP, 32'h00);
		tick(3'h1, 1);
		rd(PWC_OFS_COUNT, 32'h0);
		rd(PWC_OFS_CTRL, 32'h98);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(PWC_OFS_CTRL, 32'h0);
		irq(1'b0);
		stop_test();
	end
endmodule : testbench

bind pwc_top pwc_top_checker chk_u (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .match_irq);
`default_nettype wire
